// ---- src/sram_pkg.sv ----
package sram_pkg;

    // core geometry: the 512K x 36 organisation, four lanes of byte plus parity
    localparam int ADDR_W      = 19;
    localparam int LANE_CNT    = 4;
    localparam int BYTE_W      = 8;
    localparam int LANE_W      = BYTE_W + 1;
    localparam int DATA_W      = LANE_CNT * BYTE_W;
    localparam int DEPTH       = 1 << ADDR_W;

    // burst counter and pipeline figures
    localparam int CNT_W       = 2;
    localparam int RD_LATENCY  = 2;
    localparam int SYNC_STAGES = 3;

    // field positions inside a stored lane
    localparam int LANE_PAR_POS = BYTE_W;

    // reset values
    localparam logic [CNT_W-1:0]  CNT_RST   = 2'h0;
    localparam logic [ADDR_W-1:0] ADDR_RST  = 19'h00000;
    localparam logic              SNZ_RST   = 1'h0;
    localparam logic              ORDER_RST = 1'h1;

    // registered control pins of the shared synchronous bus
    typedef struct packed {
        logic [ADDR_W-1:0]   addr;
        logic                chip_select_n;
        logic                expansion_select_hi;
        logic                expansion_select_lo_n;
        logic                controller_addr_strobe_n;
        logic                processor_addr_strobe_n;
        logic                burst_advance_n;
        logic                lane_write_enable_n;
        logic                all_lane_write_n;
        logic [LANE_CNT-1:0] byte_write_sel_n;
    } bus_ctrl_s;

    // data pins: byte lanes plus one parity bit per lane
    typedef struct packed {
        logic [LANE_CNT-1:0] parity_lanes;
        logic [DATA_W-1:0]   data_lanes;
    } bus_data_s;

    localparam bus_ctrl_s CTRL_IDLE = '{
        addr: ADDR_RST, chip_select_n: 1'h1, expansion_select_hi: 1'h0,
        expansion_select_lo_n: 1'h1, controller_addr_strobe_n: 1'h1,
        processor_addr_strobe_n: 1'h1, burst_advance_n: 1'h1,
        lane_write_enable_n: 1'h1, all_lane_write_n: 1'h1,
        byte_write_sel_n: 4'hF};

    localparam bus_data_s DATA_RST = '{parity_lanes: 4'h0, data_lanes: 32'h00000000};

    typedef enum logic [1:0] {OP_IDLE, OP_READ, OP_WRITE} op_e;
    typedef enum logic {ST_DESELECTED, ST_ACTIVE} burst_state_e;

endpackage

// ---- src/burst_sram.sv ----
// Notes on behaviour
// - every synchronous pin is registered on the rising clock edge.
// - two extra registered chip selects allow depth expansion.
// - core is 1M x 18 or 512K x 32/36; this build is 512K x 36.
// - a two-bit burst counter supplies the low address bits.
// - either address strobe starts a burst and loads the presented address.
// - later burst addresses come from the counter, stepped by burst advance.
// - burst order pin chooses interleaved or linear stepping.
// - data drivers are on only while async output enable is low.
// - data in and out share pins; the host must not drive during reads.
// - output enable, clock and snooze are not captured by input registers.
// - a write updates any chosen subset of byte lanes.
// - each byte select gates its own byte and parity bit.
// - global write low writes every lane regardless of byte selects.
// - parity lanes exist on x18 and x36 only, not on x32.
// - writes are registered and self-timed, no external write pulse.
// - after a deselect the drivers stay on one more cycle.
// - snooze enable enters a low-power standby mode.
// - order pin low is linear, high interleaved; host keeps it static.
// - advance high holds the address; host holds it high after processor write.
// - processor strobe is ignored with chip select high and always reads.
// - in snooze all other inputs are ignored and contents kept.
module burst_sram (
    // clock, reset, enable
    input  wire logic                i_clk,
    input  wire logic                i_sys_rst,
    input  wire logic                i_clk_en,
    // synchronous bus pins
    input  wire sram_pkg::bus_ctrl_s i_ctrl,
    input  wire sram_pkg::bus_data_s i_dq,
    // data pin drive side
    output sram_pkg::bus_data_s      o_dq,
    output logic                     o_dq_oe_n,
    // asynchronous pins
    input  wire logic                i_out_enable_n,
    input  wire logic                i_snooze_request,
    input  wire logic                i_burst_order_select
);

    sram_pkg::bus_ctrl_s                 ctrl_r;
    sram_pkg::bus_data_s                 dq_r;
    logic [1:0]                          async_pins;
    logic [1:0]                          async_filt_r;
    logic                                snz_r;
    logic                                order_r;
    sram_pkg::burst_state_e              state_r;
    sram_pkg::burst_state_e              state_nxt;
    logic [sram_pkg::ADDR_W-1:0]         base_r;
    logic [sram_pkg::ADDR_W-1:0]         base_nxt;
    logic [sram_pkg::CNT_W-1:0]          cnt_r;
    logic [sram_pkg::CNT_W-1:0]          cnt_nxt;
    logic [sram_pkg::ADDR_W-1:0]         eff_addr;
    sram_pkg::op_e                       op;
    logic                                sel_ok;
    logic                                p_start;
    logic                                c_start;
    logic                                load;
    logic                                wr_req;
    logic [sram_pkg::LANE_CNT-1:0]       lane_we;
    logic [sram_pkg::LANE_CNT*sram_pkg::LANE_W-1:0] rd_word;
    logic                                rd_v1_r;
    logic                                drive_n_r;
    logic                                ext_r;

    // input registers for every synchronous pin
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ctrl_r <= sram_pkg::CTRL_IDLE;
            dq_r   <= sram_pkg::DATA_RST;
        end else if (i_clk_en) begin
            ctrl_r <= i_ctrl;
            dq_r   <= i_dq;
        end
    end

    // three-stage synchronisers for snooze and burst order, kept out of ctrl_r
    assign async_pins = {i_burst_order_select, i_snooze_request};
    for (genvar s = 0; s < 2; s++) begin : g_sync
        logic [sram_pkg::SYNC_STAGES-1:0] sh_r;
        logic                             filt_r;
        always_ff @(posedge i_clk or posedge i_sys_rst) begin
            if (i_sys_rst) begin
                sh_r   <= (s == 0) ? 3'h0 : 3'h7;
                filt_r <= (s == 0) ? sram_pkg::SNZ_RST : sram_pkg::ORDER_RST;
            end else if (i_clk_en) begin
                sh_r <= {sh_r[1:0], async_pins[s]};
                if (sh_r[1] == sh_r[2]) begin
                    filt_r <= sh_r[2]; // change accepted once stages agree
                end
            end
        end
        assign async_filt_r[s] = filt_r;
    end
    assign snz_r   = async_filt_r[0];
    assign order_r = async_filt_r[1];

    // decode of the registered cycle
    always_comb begin
        sel_ok  = !ctrl_r.chip_select_n && ctrl_r.expansion_select_hi
                  && !ctrl_r.expansion_select_lo_n;
        p_start = !ctrl_r.processor_addr_strobe_n && !ctrl_r.chip_select_n;
        c_start = !ctrl_r.controller_addr_strobe_n;
        load    = p_start || c_start;
        wr_req  = !ctrl_r.all_lane_write_n
                  || (!ctrl_r.lane_write_enable_n && !(&ctrl_r.byte_write_sel_n));
        if (!ctrl_r.all_lane_write_n) begin
            lane_we = '1;
        end else if (!ctrl_r.lane_write_enable_n) begin
            lane_we = ~ctrl_r.byte_write_sel_n;
        end else begin
            lane_we = '0;
        end
    end

    // burst state machine: load, advance, hold or deselect
    always_comb begin
        state_nxt = state_r;
        base_nxt  = base_r;
        cnt_nxt   = cnt_r;
        op        = sram_pkg::OP_IDLE;
        if (snz_r) begin
            op = sram_pkg::OP_IDLE;
        end else if (load) begin
            if (!sel_ok) begin
                state_nxt = sram_pkg::ST_DESELECTED;
            end else begin
                state_nxt = sram_pkg::ST_ACTIVE;
                base_nxt  = ctrl_r.addr;
                cnt_nxt   = sram_pkg::CNT_RST;
                if (p_start || !wr_req) begin
                    op = sram_pkg::OP_READ;
                end else begin
                    op = sram_pkg::OP_WRITE;
                end
            end
        end else begin
            case (state_r)
                sram_pkg::ST_ACTIVE: begin
                    if (!ctrl_r.burst_advance_n) begin
                        cnt_nxt = cnt_r + 2'h1;
                    end // advance high holds the address
                    op = wr_req ? sram_pkg::OP_WRITE : sram_pkg::OP_READ;
                end
                default: begin
                    op = sram_pkg::OP_IDLE;
                end
            endcase
        end
    end

    // low address bits from the counter in the chosen order
    always_comb begin
        eff_addr = base_nxt;
        if (order_r) begin
            eff_addr[1:0] = base_nxt[1:0] ^ cnt_nxt;
        end else begin
            eff_addr[1:0] = base_nxt[1:0] + cnt_nxt;
        end
    end

    // burst registers
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state_r <= sram_pkg::ST_DESELECTED;
            base_r  <= sram_pkg::ADDR_RST;
            cnt_r   <= sram_pkg::CNT_RST;
        end else if (i_clk_en) begin
            state_r <= state_nxt;
            base_r  <= base_nxt;
            cnt_r   <= cnt_nxt;
        end
    end

    // one array per lane, each lane holds its byte and its parity bit
    for (genvar l = 0; l < sram_pkg::LANE_CNT; l++) begin : g_lane
        logic [sram_pkg::LANE_W-1:0] lane_mem [sram_pkg::DEPTH];
        logic [sram_pkg::LANE_W-1:0] lane_rd_r;
        always_ff @(posedge i_clk) begin
            if (i_clk_en && op == sram_pkg::OP_WRITE && lane_we[l]) begin
                lane_mem[eff_addr] <= {dq_r.parity_lanes[l],
                                       dq_r.data_lanes[l*sram_pkg::BYTE_W +: sram_pkg::BYTE_W]};
            end // self-timed: written on the edge after capture
            if (i_clk_en && op == sram_pkg::OP_READ) begin
                lane_rd_r <= lane_mem[eff_addr];
            end
        end
        assign rd_word[l*sram_pkg::LANE_W +: sram_pkg::LANE_W] = lane_rd_r;
    end

    // output register stage of the read pipeline
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_dq <= sram_pkg::DATA_RST;
        end else if (i_clk_en && rd_v1_r) begin
            for (int l = 0; l < sram_pkg::LANE_CNT; l++) begin
                o_dq.data_lanes[l*sram_pkg::BYTE_W +: sram_pkg::BYTE_W] <=
                    rd_word[l*sram_pkg::LANE_W +: sram_pkg::BYTE_W];
                o_dq.parity_lanes[l] <= rd_word[l*sram_pkg::LANE_W + sram_pkg::LANE_PAR_POS];
            end
        end
    end

    // driver enable pipeline with one extra cycle after a deselect
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            rd_v1_r   <= 1'h0;
            drive_n_r <= 1'h1;
            ext_r     <= 1'h0;
        end else if (i_clk_en) begin
            rd_v1_r <= (op == sram_pkg::OP_READ);
            if (snz_r) begin
                drive_n_r <= 1'h1;
                ext_r     <= 1'h0;
            end else if (rd_v1_r) begin
                drive_n_r <= 1'h0;
                ext_r     <= 1'h0;
            end else if (!drive_n_r && !ext_r) begin
                drive_n_r <= 1'h0;
                ext_r     <= 1'h1;
            end else begin
                drive_n_r <= 1'h1;
                ext_r     <= 1'h0;
            end
        end
    end

    // async output enable gates the pin drivers, clock not involved
    assign o_dq_oe_n = drive_n_r || i_out_enable_n;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    AST_INPUT_CAPTURE: assert property (i_clk_en |=> ctrl_r == $past(i_ctrl))
        else $error("synchronous pins not captured");
    AST_OE_GATE: assert property (i_out_enable_n |-> o_dq_oe_n)
        else $error("drivers on with output enable high");
    AST_READ_LATENCY: assert property ((op == sram_pkg::OP_READ && i_clk_en)
        ##1 (i_clk_en && !snz_r) |=> !drive_n_r)
        else $error("read data not driven two edges after address");
    AST_DESELECT_EXTEND: assert property ((!drive_n_r && !ext_r && !rd_v1_r
        && !snz_r && i_clk_en) |=> !drive_n_r && ext_r)
        else $error("drivers not kept one extra cycle");
    AST_DRIVE_OFF: assert property ((ext_r && !rd_v1_r && i_clk_en) |=> drive_n_r)
        else $error("drivers kept beyond the extra cycle");
    AST_PROC_READ: assert property ((p_start && sel_ok && !snz_r)
        |-> op == sram_pkg::OP_READ)
        else $error("processor strobe did not read");
    AST_PROC_IGNORED: assert property ((ctrl_r.chip_select_n && !c_start && !snz_r
        && state_r == sram_pkg::ST_DESELECTED) |-> op == sram_pkg::OP_IDLE)
        else $error("processor strobe honoured with chip select high");
    AST_LOAD: assert property ((load && sel_ok && !snz_r && i_clk_en)
        |=> base_r == $past(ctrl_r.addr) && cnt_r == sram_pkg::CNT_RST)
        else $error("address not loaded on strobe");
    AST_ADVANCE: assert property ((state_r == sram_pkg::ST_ACTIVE && !load && !snz_r
        && !ctrl_r.burst_advance_n && i_clk_en)
        |=> cnt_r == $past(cnt_r) + 2'h1)
        else $error("burst counter did not advance");
    AST_HOLD: assert property ((state_r == sram_pkg::ST_ACTIVE && !load && !snz_r
        && ctrl_r.burst_advance_n && i_clk_en) |=> $stable(cnt_r))
        else $error("burst counter moved while held");
    AST_GLOBAL_WRITE: assert property (!ctrl_r.all_lane_write_n |-> &lane_we)
        else $error("global write missed a lane");
    AST_SNOOZE: assert property ((snz_r && i_clk_en) |=> $stable(state_r)
        && $stable(cnt_r) && !rd_v1_r)
        else $error("activity during snooze");

    // no lane may open unless a global or byte write is requested
    // this catches a stray lane enable that would corrupt stored bytes
    AST_LANE_WRITE_GATE: assert property (ctrl_r.all_lane_write_n
        && ctrl_r.lane_write_enable_n |-> lane_we == 4'h0)
        else $error("lane written without write enable");

    // each byte select opens exactly its own lane and parity bit
    // with global write high and lane write enable low the selects alone decide
    AST_BYTE_SELECT: assert property (ctrl_r.all_lane_write_n
        && !ctrl_r.lane_write_enable_n |-> lane_we == ~ctrl_r.byte_write_sel_n)
        else $error("byte select opened the wrong lane");

    // a write cycle needs a write request and no snooze
    // snooze must never let a write reach the array
    AST_WRITE_NEEDS_REQ: assert property (op == sram_pkg::OP_WRITE
        |-> wr_req && !snz_r)
        else $error("write without write request");

    // a read cycle enters the output pipeline on the next edge
    // the pipeline stage is what gives the two-edge latency
    AST_READ_PIPE: assert property ((op == sram_pkg::OP_READ && i_clk_en)
        |=> rd_v1_r)
        else $error("read did not enter the pipeline");

    // a load with the expansion selects false deselects the device
    // this is how banks of several devices share one bus
    AST_DESELECT_STATE: assert property ((load && !sel_ok && !snz_r
        && i_clk_en) |=> state_r == sram_pkg::ST_DESELECTED)
        else $error("deselect not taken");

    // a deselected device does no array work until the next load
    // otherwise a foreign bank's cycles would be served here
    AST_DESELECT_NO_OP: assert property ((state_r == sram_pkg::ST_DESELECTED
        && !load) |-> op == sram_pkg::OP_IDLE)
        else $error("array used while deselected");

    // the first access of a burst uses the presented address as is
    // the counter starts at zero in both orders
    AST_FIRST_ADDR: assert property ((load && sel_ok && !snz_r)
        |-> eff_addr == ctrl_r.addr)
        else $error("first burst address wrong");

    // the two-bit counter wraps after the fourth word
    // burst never leaves its aligned group of four
    AST_WRAP: assert property ((state_r == sram_pkg::ST_ACTIVE && !load && !snz_r
        && !ctrl_r.burst_advance_n && cnt_r == 2'h3 && i_clk_en) |=> cnt_r == sram_pkg::CNT_RST)
        else $error("burst counter did not wrap");

    // the upper address bits never move inside a burst
    // only the two low bits follow the counter
    AST_UPPER_FIXED: assert property ((state_r == sram_pkg::ST_ACTIVE
        && !load && !snz_r) |-> eff_addr[sram_pkg::ADDR_W-1:2] == base_r[sram_pkg::ADDR_W-1:2])
        else $error("upper burst address moved");

    // snooze turns the data drivers off on the next edge
    // a sleeping device must not hold the shared bus
    AST_SNOOZE_DRIVE_OFF: assert property ((snz_r && i_clk_en) |=> drive_n_r)
        else $error("drivers on during snooze");

    // read data holds when no read result arrives
    // o_dq keeps its last word between reads while the pins are released
    AST_OUT_HOLD: assert property ((!rd_v1_r && i_clk_en) |=> $stable(o_dq))
        else $error("read data changed without a read");

    // clock enable low freezes the captured pins and burst state
    // nothing may move while the enable is held low
    AST_FREEZE: assert property (!i_clk_en |=> $stable(state_r)
        && $stable(cnt_r) && $stable(ctrl_r))
        else $error("state moved with clock enable low");

    COV_BURST_WRAP: cover property ((state_r == sram_pkg::ST_ACTIVE
        && !ctrl_r.burst_advance_n && i_clk_en)[*4]);
    COV_PROC_WRITE: cover property (p_start && sel_ok ##1 op == sram_pkg::OP_WRITE);
    COV_DESELECT_TAIL: cover property (ext_r ##1 drive_n_r);
    COV_SNOOZE: cover property (!snz_r ##1 snz_r);
    COV_CLK_FREEZE: cover property (!i_clk_en ##1 i_clk_en);

endmodule

// ---- test/bus_host.sv ----
module bus_host (
    // clock
    input  wire logic                i_clk,
    // device side of the shared data pins
    input  wire sram_pkg::bus_data_s i_dev_dq,
    input  wire logic                i_dev_oe_n,
    // pins driven toward the device
    output sram_pkg::bus_ctrl_s      o_ctrl,
    output sram_pkg::bus_data_s      o_pin,
    output logic                     o_clash
);
    timeunit 1ns;
    timeprecision 1ps;

    sram_pkg::bus_data_s host_dq_r;
    sram_pkg::bus_data_s last_r;
    logic                drv_r;

    // idle pins until the first cycle is sent
    initial begin
        o_ctrl    = sram_pkg::CTRL_IDLE;
        host_dq_r = sram_pkg::DATA_RST;
        last_r    = sram_pkg::DATA_RST;
        drv_r     = 1'h0;
        o_clash   = 1'h0;
    end

    // resolved pin level: a released bus shows a pattern changing every cycle
    assign o_pin = !i_dev_oe_n ? i_dev_dq
                 : (drv_r ? host_dq_r : sram_pkg::bus_data_s'(~last_r));

    // remember the last level and flag two drivers on the pins at once
    always @(posedge i_clk) begin
        last_r <= o_pin;
        if (drv_r && !i_dev_oe_n) begin
            o_clash <= 1'h1;
        end
    end

    // one bus cycle: pins change just after an edge and hold until the next one
    task automatic send(input sram_pkg::bus_ctrl_s c, input sram_pkg::bus_data_s d,
                        input logic drv);
        @(posedge i_clk);
        o_ctrl    <= c;
        host_dq_r <= d;
        drv_r     <= drv;
    endtask
endmodule

// ---- test/tb_top.sv ----
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic                clk;
    logic                sys_rst;
    logic                clk_en;
    logic                out_enable_n;
    logic                snooze_request;
    logic                burst_order_select;
    logic                oe_n;
    logic                clash;
    sram_pkg::bus_ctrl_s ctrl;
    sram_pkg::bus_data_s pin;
    sram_pkg::bus_data_s dq;
    int                  errors;
    int                  comparisons;
    int                  cycles;

    burst_sram i_dut (.i_clk(clk), .i_sys_rst(sys_rst), .i_clk_en(clk_en), .i_ctrl(ctrl),
        .i_dq(pin), .o_dq(dq), .o_dq_oe_n(oe_n), .i_out_enable_n(out_enable_n),
        .i_snooze_request(snooze_request), .i_burst_order_select(burst_order_select));
    bus_host i_host (.i_clk(clk), .i_dev_dq(dq), .i_dev_oe_n(oe_n), .o_ctrl(ctrl),
        .o_pin(pin), .o_clash(clash));

    // clock
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end

    // kind 0 selected idle, 1 controller load, 2 deselect, 3 processor load
    function automatic sram_pkg::bus_ctrl_s cyc(input logic [18:0] a, input int k);
        sram_pkg::bus_ctrl_s c;
        c = sram_pkg::CTRL_IDLE;
        c.addr = a;
        c.chip_select_n = 1'h0;
        c.expansion_select_lo_n = 1'h0;
        c.expansion_select_hi = (k != 2);
        c.controller_addr_strobe_n = !(k == 1 || k == 2);
        c.processor_addr_strobe_n = (k != 3);
        return c;
    endfunction

    task automatic check(input string what, input logic [35:0] exp, input logic [35:0] got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [18:0] a, input logic [35:0] d, input logic [3:0] bsel_n,
                      input logic glob_n, input logic lwe_n);
        sram_pkg::bus_ctrl_s c;
        c = cyc(a, 1);
        c.all_lane_write_n = glob_n;
        c.lane_write_enable_n = lwe_n;
        c.byte_write_sel_n = bsel_n;
        i_host.send(c, d, 1'h1);
        i_host.send(cyc('0, 2), '0, 1'h0);
    endtask

    task automatic rd(input logic [18:0] a, input logic [35:0] exp);
        i_host.send(cyc(a, 1), '0, 1'h0);
        i_host.send(cyc('0, 2), '0, 1'h0);
        repeat (2) @(posedge clk);
        #1;
        check("read data", exp, dq);
        check("drive on", 36'h0, {35'h0, oe_n});
        @(posedge clk);
        #1;
        check("drive kept", 36'h0, {35'h0, oe_n});
        @(posedge clk);
        #1;
        check("drive off", 36'h1, {35'h0, oe_n});
    endtask

    task automatic t_lanes();
        logic [35:0] exp;
        wr(19'h00010, 36'hE_1234_5678, 4'hF, 1'h0, 1'h1);
        rd(19'h00010, 36'hE_1234_5678);
        wr(19'h00010, 36'h0, 4'hF, 1'h0, 1'h1);
        exp = 36'h0;
        for (int i = 0; i < 4; i++) begin
            wr(19'h00010, 36'hF_FFFF_FFFF, ~(4'h1 << i), 1'h1, 1'h0);
            exp = exp | (36'hFF << (8 * i)) | (36'h1 << (32 + i));
            rd(19'h00010, exp);
        end
        wr(19'h00010, 36'h0, 4'h0, 1'h1, 1'h1);
        rd(19'h00010, exp);
        $display("test lanes done");
    endtask

    task automatic t_burst(input logic lin);
        sram_pkg::bus_ctrl_s c;
        logic [1:0]          s;
        int                  n;
        burst_order_select <= !lin;
        repeat (4) @(posedge clk);
        for (int k = 0; k < 4; k++) begin
            wr(19'(19'h00100 + k), 36'(36'h0_A5A5_0000 + k), 4'hF, 1'h0, 1'h1);
        end
        for (int k = 0; k < 8; k++) begin
            c = (k == 0) ? cyc(19'h00101, 1) : ((k < 5) ? cyc('0, 0) : cyc('0, 2));
            c.burst_advance_n = !(k == 1 || k == 3 || k == 4);
            i_host.send(c, '0, 1'h0);
            #1;
            if (k >= 3) begin
                n = (k - 3) - ((k - 3) > 1);
                s = lin ? 2'(1 + n) : (2'h1 ^ 2'(n));
                check("burst word", 36'h0_A5A5_0000 + s, dq);
            end
        end
        repeat (3) @(posedge clk);
        $display("test burst done");
    endtask

    task automatic t_proc();
        sram_pkg::bus_ctrl_s c;
        c = cyc(19'h00200, 3);
        c.chip_select_n = 1'h1;
        i_host.send(c, '0, 1'h0);
        i_host.send(cyc('0, 0), '0, 1'h0);
        repeat (2) @(posedge clk);
        #1;
        check("ignored strobe", 36'h1, {35'h0, oe_n});
        wr(19'h00200, 36'hE_1234_5678, 4'hF, 1'h0, 1'h1);
        c = cyc(19'h00200, 3);
        c.all_lane_write_n = 1'h0;
        i_host.send(c, '0, 1'h0);
        i_host.send(cyc('0, 2), '0, 1'h0);
        repeat (4) @(posedge clk);
        rd(19'h00200, 36'hE_1234_5678);
        i_host.send(cyc(19'h00200, 3), '0, 1'h0);
        c = cyc('0, 0);
        c.lane_write_enable_n = 1'h0;
        c.byte_write_sel_n = 4'hE;
        i_host.send(c, 36'h1_0000_00C3, 1'h1);
        i_host.send(cyc('0, 2), '0, 1'h0);
        repeat (4) @(posedge clk);
        rd(19'h00200, 36'hF_1234_56C3);
        $display("test processor done");
    endtask

    task automatic t_enable();
        sram_pkg::bus_ctrl_s c;
        c = cyc(19'h00200, 1);
        c.expansion_select_lo_n = 1'h1;
        i_host.send(c, '0, 1'h0);
        i_host.send(cyc('0, 0), '0, 1'h0);
        repeat (2) @(posedge clk);
        #1;
        check("expansion deselect", 36'h1, {35'h0, oe_n});
        i_host.send(cyc(19'h00200, 1), '0, 1'h0);
        i_host.send(cyc('0, 0), '0, 1'h0);
        repeat (3) @(posedge clk);
        out_enable_n <= 1'h1;
        #1;
        check("output enable off", 36'h1, {35'h0, oe_n});
        @(posedge clk);
        out_enable_n <= 1'h0;
        #1;
        check("output enable on", 36'h0, {35'h0, oe_n});
        check("held word", 36'hF_1234_56C3, dq);
        clk_en <= 1'h0;
        repeat (3) @(posedge clk);
        #1;
        check("frozen drive", 36'h0, {35'h0, oe_n});
        clk_en <= 1'h1;
        i_host.send(cyc('0, 2), '0, 1'h0);
        repeat (4) @(posedge clk);
        snooze_request <= 1'h1;
        repeat (5) @(posedge clk);
        wr(19'h00200, 36'h0, 4'hF, 1'h0, 1'h1);
        snooze_request <= 1'h0;
        repeat (5) @(posedge clk);
        rd(19'h00200, 36'hF_1234_56C3);
        $display("test enable done");
    endtask

    task automatic complete_run();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // cut a hang short
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            complete_run();
        end
    end

    // main sequence
    initial begin
        sys_rst = 1'h1;
        clk_en = 1'h1;
        out_enable_n = 1'h0;
        snooze_request = 1'h0;
        burst_order_select = 1'h1;
        errors = 0;
        comparisons = 0;
        cycles = 0;
        repeat (12) @(posedge clk);
        sys_rst <= 1'h0;
        t_lanes();
        t_burst(1'h0);
        t_burst(1'h1);
        t_proc();
        t_enable();
        check("bus clash", 36'h0, {35'h0, clash});
        complete_run();
    end
endmodule
